// *** design/afe_pin_control.sv ***
// Top of the front-end pin control block
`timescale 1ns/1ps
module afe_pin_control (
	input wire logic CORE_CLK, // Master clock, 25 MHz
	input wire logic RSTN, // Active-low master reset
	input wire afe_pin_pkg::settings_t SETTINGS, // Configuration bits
	input wire logic [1:0] MOD_BITS, // Raw modulator decisions per channel
	output logic MOD_CH0_OUT, // Channel 0 bitstream level
	output logic MOD_CH0_OE, // Channel 0 drive enable
	output logic MOD_CH1_OUT, // Channel 1 bitstream level
	output logic MOD_CH1_OE, // Channel 1 drive enable
	output logic DATA_READY_N_OUT, // Data-ready level
	output logic DATA_READY_N_OE, // Data-ready drive enable
	output logic CRYSTAL_OSC_ENABLE, // Crystal oscillator on
	output logic CRYSTAL_OUT_ENABLE, // Second oscillator pin active
	output logic INTERNAL_REF_ENABLE, // Internal reference and switch on
	output logic ANALOG_BIAS_ENABLE, // Analog biases on
	output logic SERIAL_ALLOWED, // Serial interface may run
	output logic CLOCKS_RUNNING, // Internal clocks distributed
	output logic ANALOG_MASTER_CLOCK_TICK, // Analog clock strobe
	output logic DIGITAL_MASTER_CLOCK_TICK, // Digital clock strobe
	output logic OUTPUT_RATE_CLOCK_TICK // Output rate strobe
);
	// ****************************************
	// Reset release
	// ****************************************
	logic [1:0] rst_sync_reg;
	logic rst_n;
	always_ff @(posedge CORE_CLK or negedge RSTN) begin
		if (!RSTN) begin
			rst_sync_reg <= 2'h0;
		end else begin
			rst_sync_reg <= {rst_sync_reg[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_reg[1];

	// ****************************************
	// Clock tree strobes
	// ****************************************
	logic analog_master_clock_tick, digital_master_clock_tick;
	afe_clock_divider u_div (
		.clk(CORE_CLK),
		.rst_n(rst_n),
		.prescale(SETTINGS.prescale),
		.analog_master_clock_tick(analog_master_clock_tick),
		.digital_master_clock_tick(digital_master_clock_tick)
	);

	function automatic logic [7:0] osr_last(input logic [1:0] code);
		osr_last = 8'(((9'h1 << code) * 9'(afe_pin_pkg::OSR_BASE_MINUS1 + 8'h1)) - 9'h1);
	endfunction : osr_last

	// ****************************************
	// Data-ready generator
	// ****************************************
	logic [7:0] osr_cnt_reg, osr_cnt_next;
	logic dr_low_reg, dr_low_next;
	logic output_rate_clock_reg, output_rate_clock_next;
	logic [1:0] mod_reg, mod_next;
	logic [1:0] mod_oe_reg, mod_oe_next;
	logic dr_oe_reg, dr_oe_next;
	logic run_reg, run_next;
	always_comb begin
		osr_cnt_next = osr_cnt_reg;
		dr_low_next = dr_low_reg;
		output_rate_clock_next = 1'b0;
		if (digital_master_clock_tick) begin
			if (osr_cnt_reg >= osr_last(SETTINGS.oversampling_ratio)) begin
				osr_cnt_next = 8'h0;
				dr_low_next = 1'b1;
				output_rate_clock_next = 1'b1;
			end else begin
				osr_cnt_next = 8'(osr_cnt_reg + 8'h1);
				dr_low_next = 1'b0;
			end
		end
		mod_next = mod_reg;
		// Sample only once clocks run, so the pin never moves without a visible tick
		if (analog_master_clock_tick && run_reg) begin
			mod_next = MOD_BITS;
		end
		mod_oe_next = SETTINGS.modulator_output_enable;
		dr_oe_next = SETTINGS.data_ready_drive_enable;
		run_next = 1'b1;
	end
	always_ff @(posedge CORE_CLK or negedge rst_n) begin
		if (!rst_n) begin
			osr_cnt_reg <= 8'h0;
			dr_low_reg <= 1'b0;
			output_rate_clock_reg <= 1'b0;
			mod_reg <= 2'h0;
			mod_oe_reg <= afe_pin_pkg::MOD_ENABLE_RESET;
			dr_oe_reg <= 1'b0;
			run_reg <= 1'b0;
		end else begin
			osr_cnt_reg <= osr_cnt_next;
			dr_low_reg <= dr_low_next;
			output_rate_clock_reg <= output_rate_clock_next;
			mod_reg <= mod_next;
			mod_oe_reg <= mod_oe_next;
			dr_oe_reg <= dr_oe_next;
			run_reg <= run_next;
		end
	end

	// ****************************************
	// Pin drive
	// ****************************************
	assign MOD_CH0_OUT = mod_reg[0];
	assign MOD_CH1_OUT = mod_reg[1];
	assign MOD_CH0_OE = mod_oe_reg[0];
	assign MOD_CH1_OE = mod_oe_reg[1];
	// Unlatched, set only by the strobe counter
	assign DATA_READY_N_OUT = ~dr_low_reg;
	assign DATA_READY_N_OE = dr_low_reg | dr_oe_reg;
	assign CRYSTAL_OSC_ENABLE = ~SETTINGS.external_clock_select;
	assign CRYSTAL_OUT_ENABLE = ~SETTINGS.external_clock_select;
	assign INTERNAL_REF_ENABLE = ~SETTINGS.external_reference_select;
	assign ANALOG_BIAS_ENABLE = 1'b1;
	assign SERIAL_ALLOWED = run_reg;
	assign CLOCKS_RUNNING = run_reg;
	assign ANALOG_MASTER_CLOCK_TICK = analog_master_clock_tick & run_reg;
	assign DIGITAL_MASTER_CLOCK_TICK = digital_master_clock_tick & run_reg;
	assign OUTPUT_RATE_CLOCK_TICK = output_rate_clock_reg;
endmodule : afe_pin_control

// *** design/afe_pin_pkg.sv ***
// Constants and carrier types for the front-end pin control block
// ****************************************
// How it works
// - Reset clears pin drive enables, blocks serial, stops clocks
// - Analog biases stay enabled during reset
// - Bitstream pins high impedance until enabled
// - Enabled channel drives bitstream each analog clock
// - Idle ready pin high or floating per enable
// - Low ready pulse after each conversion
// - Pulse one digital period, repeats at rate
// - Ready pulse unlatched, independent of serial
// - Select zero runs crystal as master clock
// - Select one disables crystal, uses input pin
// - Reference select zero enables internal reference
// - Analog clock is master over 1,2,4,8
// - Digital clock is analog clock over four
// - Rate clock is digital over oversampling ratio
// ****************************************
package afe_pin_pkg;
	localparam logic [1:0] PRESCALE_RESET = 2'h0;
	localparam logic [1:0] OSR_RESET = 2'h1;
	localparam logic [1:0] MOD_ENABLE_RESET = 2'h0;
	localparam logic [2:0] ANALOG_MASTER_CLOCK_PER_DIGITAL_MASTER_CLOCK = 3'h4;
	localparam logic [7:0] OSR_BASE_MINUS1 = 8'h1F;

	typedef struct packed {
		logic [1:0] prescale;
		logic [1:0] oversampling_ratio;
		logic [1:0] modulator_output_enable;
		logic data_ready_drive_enable;
		logic external_clock_select;
		logic external_reference_select;
	} settings_t;

	typedef struct packed {
		logic out;
		logic oe;
	} pin_out_t;
endpackage : afe_pin_pkg

// *** design/afe_clock_divider.sv ***
// Prescaler and divide-by-four producing analog and digital strobes
`timescale 1ns/1ps
module afe_clock_divider (
	input wire logic clk, // Master clock
	input wire logic rst_n, // Synchronised reset
	input wire logic [1:0] prescale, // Prescale code
	output logic analog_master_clock_tick, // One cycle per analog clock period
	output logic digital_master_clock_tick // One cycle per digital clock period
);
	logic [2:0] pre_reg, pre_next;
	logic [1:0] quad_reg, quad_next;
	logic [2:0] pre_max;
	always_comb begin
		pre_max = 3'((4'h1 << prescale) - 4'h1);
		analog_master_clock_tick = (pre_reg >= pre_max);
		pre_next = analog_master_clock_tick ? 3'h0 : 3'(pre_reg + 3'h1);
		quad_next = quad_reg;
		if (analog_master_clock_tick) begin
			quad_next = 2'(quad_reg + 2'h1);
		end
		digital_master_clock_tick = analog_master_clock_tick && (quad_reg == 2'(afe_pin_pkg::ANALOG_MASTER_CLOCK_PER_DIGITAL_MASTER_CLOCK - 3'h1));
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pre_reg <= 3'h0;
			quad_reg <= 2'h0;
		end else begin
			pre_reg <= pre_next;
			quad_reg <= quad_next;
		end
	end
endmodule : afe_clock_divider

// *** bench/afe_pin_control_asserts.sv ***
// Port assertions for the pin control block
`timescale 1ns/1ps
module afe_pin_control_asserts (
	input wire logic CORE_CLK, // Clock
	input wire logic RSTN, // Reset
	input wire afe_pin_pkg::settings_t SETTINGS, // Settings
	input wire logic MOD_CH0_OUT, // Bitstream
	input wire logic MOD_CH0_OE, // Enable
	input wire logic DATA_READY_N_OUT, // Ready
	input wire logic DATA_READY_N_OE, // Ready enable
	input wire logic INTERNAL_REF_ENABLE, // Reference
	input wire logic ANALOG_BIAS_ENABLE, // Bias
	input wire logic SERIAL_ALLOWED, // Run
	input wire logic ANALOG_MASTER_CLOCK_TICK, // Analog strobe
	input wire logic DIGITAL_MASTER_CLOCK_TICK, // Digital strobe
	input wire logic OUTPUT_RATE_CLOCK_TICK // Rate strobe
);
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (!RSTN);
	sequence s_low4;
		(!DATA_READY_N_OUT) [*4] ##1 DATA_READY_N_OUT;
	endsequence
	a_bias_on: assert property (ANALOG_BIAS_ENABLE) else $error("bias");
	a_ref_select: assert property (INTERNAL_REF_ENABLE == !SETTINGS.external_reference_select)
		else $error("ref");
	a_reset_quiet: assert property (!SERIAL_ALLOWED |-> DATA_READY_N_OUT && !DIGITAL_MASTER_CLOCK_TICK)
		else $error("quiet");
	a_pulse_width: assert property ($fell(DATA_READY_N_OUT) && SETTINGS.prescale == 2'h0
		|-> s_low4) else $error("width");
	a_pulse_rate: assert property ($fell(DATA_READY_N_OUT) |-> OUTPUT_RATE_CLOCK_TICK) else $error("rate");
	a_bit_hold: assert property ($changed(MOD_CH0_OUT) |-> $past(ANALOG_MASTER_CLOCK_TICK))
		else $error("bit");
	a_bit_enable: assert property (SERIAL_ALLOWED && $past(SERIAL_ALLOWED)
		|-> MOD_CH0_OE == $past(SETTINGS.modulator_output_enable[0])) else $error("oe");
	a_idle_drive: assert property (DATA_READY_N_OUT && $past(DATA_READY_N_OUT) && SERIAL_ALLOWED
		|-> DATA_READY_N_OE == $past(SETTINGS.data_ready_drive_enable)) else $error("idle");
endmodule : afe_pin_control_asserts
bind afe_pin_control afe_pin_control_asserts chk_u (.*);

// *** bench/afe_host_model.sv ***
// Host model seeing the ready and bitstream lines
`timescale 1ns/1ps
module afe_host_model (
	input wire logic clk, // Clock
	input wire logic rdy_out, // Ready level
	input wire logic rdy_oe, // Ready enable
	input wire logic bit_out, // Bitstream level
	input wire logic bit_oe, // Bitstream enable
	output logic rdy, // Ready line
	output logic bit_level // Bitstream line
);
	logic last_reg;
	always_ff @(posedge clk) last_reg <= bit_level;
	// Pull-up when released
	assign rdy = rdy_oe ? rdy_out : 1'h1;
	// Floating line flips
	assign bit_level = bit_oe ? bit_out : ~last_reg;
endmodule : afe_host_model

// *** bench/test_afe_pin_control.sv ***
// Bench for the pin control block
`timescale 1ns/1ps
module test_afe_pin_control;
	logic clk, rstn, e0, e1, m1, dro, droe, cko, rfe, ser, run, rdy, osc;
	afe_pin_pkg::settings_t cfg;
	logic [1:0] mod;
	int bad_count, cmp_count, cyc;
	afe_pin_control dut_u (.CORE_CLK(clk), .RSTN(rstn), .SETTINGS(cfg), .MOD_BITS(mod),
		.MOD_CH0_OUT(), .MOD_CH0_OE(e0), .MOD_CH1_OUT(m1), .MOD_CH1_OE(e1),
		.DATA_READY_N_OUT(dro), .DATA_READY_N_OE(droe), .CRYSTAL_OSC_ENABLE(osc),
		.CRYSTAL_OUT_ENABLE(cko), .INTERNAL_REF_ENABLE(rfe), .ANALOG_BIAS_ENABLE(),
		.SERIAL_ALLOWED(ser), .CLOCKS_RUNNING(run), .ANALOG_MASTER_CLOCK_TICK(), .DIGITAL_MASTER_CLOCK_TICK(), .OUTPUT_RATE_CLOCK_TICK());
	afe_host_model host_u (.clk(clk), .rdy_out(dro), .rdy_oe(droe), .bit_out(m1), .bit_oe(e1),
		.rdy(rdy), .bit_level());
	initial begin
		clk = 1'h0;
		forever #20 clk = ~clk;
	end
	always @(posedge clk) begin
		mod <= mod + 2'h1;
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			bad_count++;
			conclude();
		end
	end
	task check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task run_case(input logic [1:0] p);
		logic [15:0] lo;
		logic [15:0] per;
		rstn <= 1'h0;
		cfg <= {p, p, p, p[0], p[1], p[0]};
		@(negedge clk);
		check("reset", {ser, run, e0, e1, droe}, 16'h0);
		@(posedge clk);
		rstn <= 1'h1;
		@(negedge rdy);
		@(negedge clk);
		lo = 16'h0;
		while (rdy === 1'h0) begin
			lo++;
			@(negedge clk);
		end
		per = lo;
		while (rdy === 1'h1) begin
			per++;
			@(negedge clk);
		end
		check("width", lo, 16'h4 << p);
		check("period", per, 16'h80 << {p, 1'h0});
		while (rdy !== 1'h1) @(negedge clk);
		check("pins", {e1, e0, droe, cko, rfe, ser, run}, {p, p[0], ~p[1], ~p[0], 2'h3});
		check("osc", {15'h0, osc}, {15'h0, ~p[1]});
		if (p == 2'h0) check("bit", {15'h0, m1}, {15'h0, 1'((mod - 2'h1) >> 1)});
		$display("test %0d done", p);
	endtask : run_case
	task conclude();
		$display("comparisons %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : conclude
	initial begin
		rstn = 1'h0;
		cfg = '0;
		mod = 2'h0;
		bad_count = 0;
		cmp_count = 0;
		cyc = 0;
		repeat (2) @(posedge clk);
		for (int i = 0; i < 4; i++) begin
			@(posedge clk);
			run_case(i[1:0]);
		end
		conclude();
	end
endmodule : test_afe_pin_control
